// [pt_paired_timer.sv]
// Design decisions made here: the placing of the registers and the plain strobed port.
`default_nettype none
module pt_paired_timer #(
  parameter bit FIRST_PAIR = 1'b1,
  parameter int PS_CNT_W   = 8
) (
  // Clock and reset
  input  wire logic                           core_clk_i,
  input  wire logic                           reset_i,
  // Register port
  input  wire logic [pt_pkg::PT_ADDR_W-1:0]   reg_addr_i,
  input  wire logic [pt_pkg::PT_DATA_W-1:0]   reg_wdata_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  output logic      [pt_pkg::PT_DATA_W-1:0]   reg_rdata_o,
  // Pins, index 0 low timer, 1 high timer
  input  wire logic [1:0]                     external_count_pin_i,
  input  wire logic [1:0]                     gate_pin_i,
  // Power state from the core clock domain
  input  wire logic                           idle_mode_i,
  // Interrupt requests toward the controller
  output logic      [1:0]                     irq_req_o,
  output logic      [pt_pkg::PT_PRI_W-1:0]    pair_irq_priority_low_o,
  output logic      [pt_pkg::PT_PRI_W-1:0]    pair_irq_priority_o,
  // Time base and converter trigger
  output logic      [pt_pkg::PT_DATA_W-1:0]   tb_count_low_o,
  output logic      [pt_pkg::PT_DATA_W-1:0]   tb_count_high_o,
  output logic      [1:0]                     tb_match_o,
  output logic                                adc_trigger_o,
  output logic                                pair_joined_o
);
  import pt_pkg::*;

  if (PS_CNT_W < 8) begin
    $error("PS_CNT_W must be at least 8");
  end

  function automatic logic [PS_CNT_W-1:0] ps_term(input logic [1:0] code);
    unique case (code)
      2'h0: ps_term = PS_CNT_W'(PT_PS_TERM_1);
      2'h1: ps_term = PS_CNT_W'(PT_PS_TERM_8);
      2'h2: ps_term = PS_CNT_W'(PT_PS_TERM_64);
      2'h3: ps_term = PS_CNT_W'(PT_PS_TERM_256);
    endcase
  endfunction

  logic [PT_DATA_W-1:0] low_timer_control_reg;
  logic [PT_DATA_W-1:0] high_timer_control_reg;
  logic [PT_DATA_W-1:0] period_word_reg [2];
  logic [PT_DATA_W-1:0] count_word_reg  [2];
  logic [PT_DATA_W-1:0] irq_ctrl_reg;
  logic [PS_CNT_W-1:0]  ps_count_reg    [2];
  logic [1:0]           ext_meta_reg;
  logic [1:0]           ext_sync_reg;
  logic [1:0]           ext_prev_reg;
  logic [1:0]           gate_meta_reg;
  logic [1:0]           gate_sync_reg;
  logic [1:0]           tb_match_reg;
  logic                 adc_trigger_reg;
  logic [PT_DATA_W-1:0] rdata_reg;

  logic                 joined;
  logic [PT_DATA_W-1:0] eff_ctrl   [2];
  logic [1:0]           run;
  logic [1:0]           raw_tick;
  logic [1:0]           ps_hit;
  logic [1:0]           tick;
  logic [1:0]           match16;
  logic                 match32;
  logic [1:0]           flag_set;
  logic [1:0]           cnt_wr;

  // Pins cross into the core clock through two flops each
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_meta_reg  <= 2'h0;
      ext_sync_reg  <= 2'h0;
      ext_prev_reg  <= 2'h0;
      gate_meta_reg <= 2'h0;
      gate_sync_reg <= 2'h0;
    end else begin
      ext_meta_reg  <= external_count_pin_i;
      ext_sync_reg  <= ext_meta_reg;
      ext_prev_reg  <= ext_sync_reg;
      gate_meta_reg <= gate_pin_i;
      gate_sync_reg <= gate_meta_reg;
    end
  end

  assign joined = low_timer_control_reg[PT_BIT_JOIN];
  assign cnt_wr[0] = reg_wr_i && (reg_addr_i == PT_OFF_LOW_CNT);
  assign cnt_wr[1] = reg_wr_i && (reg_addr_i == PT_OFF_HIGH_CNT);

  // Tick generation per timer; in joined mode both use the low timer's setup
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      automatic int src = (joined) ? 0 : i;
      eff_ctrl[i] = (i == 1 && !joined) ? high_timer_control_reg
                                        : low_timer_control_reg;
      // Sleep leaves the core clock running, so only idle can halt
      run[i] = eff_ctrl[i][PT_BIT_RUN] && !(idle_mode_i && eff_ctrl[i][PT_BIT_IDLE])
               && !(i == 1 && joined);
      if (eff_ctrl[i][PT_BIT_CKS]) begin
        // Edges are seen on the synchronised pin only, never asynchronously
        raw_tick[i] = ext_sync_reg[src] && !ext_prev_reg[src];
      end else if (eff_ctrl[i][PT_BIT_GATE]) begin
        raw_tick[i] = gate_sync_reg[src];
      end else begin
        raw_tick[i] = 1'b1;
      end
      // At or past terminal, so lowering the ratio mid-run cannot stall the count
      ps_hit[i] = ps_count_reg[i] >= ps_term(eff_ctrl[i][PT_BIT_PS_LSB +: 2]);
      tick[i]   = run[i] && raw_tick[i] && ps_hit[i];
      match16[i] = count_word_reg[i] == period_word_reg[i];
    end
  end

  assign match32 = {count_word_reg[1], count_word_reg[0]} ==
                   {period_word_reg[1], period_word_reg[0]};

  // Prescalers restart from zero whenever their timer is stopped
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ps_count_reg[0] <= '0;
      ps_count_reg[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!run[i]) begin
          ps_count_reg[i] <= '0;
        end else if (raw_tick[i]) begin
          ps_count_reg[i] <= ps_hit[i] ? '0 : ps_count_reg[i] + 1'b1;
        end
      end
    end
  end

  // Counters; a software write to a count word wins over a tick
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_word_reg[0] <= PT_CNT_RST;
      count_word_reg[1] <= PT_CNT_RST;
    end else if (joined) begin
      if (cnt_wr[0] || cnt_wr[1]) begin
        if (cnt_wr[0]) begin
          count_word_reg[0] <= reg_wdata_i;
        end
        if (cnt_wr[1]) begin
          count_word_reg[1] <= reg_wdata_i;
        end
      end else if (tick[0]) begin
        if (match32) begin
          count_word_reg[0] <= PT_CNT_RST;
          count_word_reg[1] <= PT_CNT_RST;
        end else begin
          {count_word_reg[1], count_word_reg[0]} <=
            {count_word_reg[1], count_word_reg[0]} + 32'h1;
        end
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cnt_wr[i]) begin
          count_word_reg[i] <= reg_wdata_i;
        end else if (tick[i]) begin
          count_word_reg[i] <= match16[i] ? PT_CNT_RST : count_word_reg[i] + 16'h1;
        end
      end
    end
  end

  // Joined match is reported on the high timer's flag only
  assign flag_set[0] = !joined && tick[0] && match16[0];
  assign flag_set[1] = joined ? (tick[0] && match32)
                              : (tick[1] && match16[1]);

  // Register writes; flags clear by writing one, a same-cycle set wins
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_timer_control_reg  <= PT_CTRL_RST;
      high_timer_control_reg <= PT_CTRL_RST;
      period_word_reg[0]     <= PT_PER_RST;
      period_word_reg[1]     <= PT_PER_RST;
      irq_ctrl_reg           <= PT_IRQ_RST;
    end else begin
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          PT_OFF_LOW_CTRL:  low_timer_control_reg  <= reg_wdata_i & PT_LOW_CTRL_MASK;
          PT_OFF_HIGH_CTRL: high_timer_control_reg <= reg_wdata_i & PT_HIGH_CTRL_MASK;
          PT_OFF_LOW_PER:   period_word_reg[0]     <= reg_wdata_i;
          PT_OFF_HIGH_PER:  period_word_reg[1]     <= reg_wdata_i;
          default: ;
        endcase
      end
      for (int i = 0; i < 2; i++) begin
        if (flag_set[i]) begin
          irq_ctrl_reg[PT_BIT_FLAG_LOW + i] <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == PT_OFF_IRQ_CTRL && reg_wdata_i[PT_BIT_FLAG_LOW + i]) begin
          irq_ctrl_reg[PT_BIT_FLAG_LOW + i] <= 1'b0;
        end
      end
      if (reg_wr_i && reg_addr_i == PT_OFF_IRQ_CTRL) begin
        irq_ctrl_reg[PT_DATA_W-1:2] <= reg_wdata_i[PT_DATA_W-1:2] & PT_IRQ_RW_MASK[PT_DATA_W-1:2];
      end
    end
  end

  // Read data stands for the one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_reg <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        PT_OFF_LOW_CTRL:  rdata_reg <= low_timer_control_reg;
        PT_OFF_HIGH_CTRL: rdata_reg <= high_timer_control_reg;
        PT_OFF_LOW_PER:   rdata_reg <= period_word_reg[0];
        PT_OFF_HIGH_PER:  rdata_reg <= period_word_reg[1];
        PT_OFF_LOW_CNT:   rdata_reg <= count_word_reg[0];
        PT_OFF_HIGH_CNT:  rdata_reg <= count_word_reg[1];
        PT_OFF_IRQ_CTRL:  rdata_reg <= irq_ctrl_reg;
        default:          rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // Consumers see match pulses and counts only on the first pair
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tb_match_reg    <= 2'h0;
      adc_trigger_reg <= 1'b0;
    end else begin
      tb_match_reg[0] <= FIRST_PAIR && tick[0] && (joined ? match32 : match16[0]);
      tb_match_reg[1] <= FIRST_PAIR && flag_set[1];
      adc_trigger_reg <= FIRST_PAIR && joined && tick[0] && match32;
    end
  end

  assign reg_rdata_o             = rdata_reg;
  assign tb_count_low_o          = FIRST_PAIR ? count_word_reg[0] : '0;
  assign tb_count_high_o         = FIRST_PAIR ? count_word_reg[1] : '0;
  assign tb_match_o              = tb_match_reg;
  assign adc_trigger_o           = adc_trigger_reg;
  assign pair_joined_o           = joined;
  assign irq_req_o[0]            = irq_ctrl_reg[PT_BIT_FLAG_LOW] && irq_ctrl_reg[PT_BIT_EN_LOW];
  assign irq_req_o[1]            = irq_ctrl_reg[PT_BIT_FLAG_HIGH] && irq_ctrl_reg[PT_BIT_EN_HIGH];
  assign pair_irq_priority_low_o = irq_ctrl_reg[PT_PRI_LOW_LSB +: PT_PRI_W];
  assign pair_irq_priority_o     = irq_ctrl_reg[PT_PRI_HIGH_LSB +: PT_PRI_W];

  default clocking pt_cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  a_read_ctrl: assert property (reg_rd_i && reg_addr_i == PT_OFF_LOW_CTRL |=>
    reg_rdata_o == $past(low_timer_control_reg))
    else $error("Control read returned wrong value");
  a_ctrl_reserved: assert property ((low_timer_control_reg & ~PT_LOW_CTRL_MASK) == '0)
    else $error("Reserved control bits set");
  a_split_incr: assert property (!joined && tick[0] && !match16[0] && !cnt_wr[0] |=>
    count_word_reg[0] == $past(count_word_reg[0]) + 16'h1)
    else $error("Split low timer did not increment");
  a_join_carry: assert property (joined && tick[0] && !match32 && !cnt_wr[0] && !cnt_wr[1] |=>
    {count_word_reg[1], count_word_reg[0]} == $past({count_word_reg[1], count_word_reg[0]}) + 32'h1)
    else $error("Joined count did not advance");
  a_join_wrap: assert property (joined && tick[0] && match32 && !cnt_wr[0] && !cnt_wr[1] |=>
    count_word_reg[0] == '0 && count_word_reg[1] == '0)
    else $error("Joined count did not wrap");
  a_join_high_flag: assert property (joined && tick[0] && match32 |=>
    irq_ctrl_reg[PT_BIT_FLAG_HIGH] && adc_trigger_o == FIRST_PAIR)
    else $error("Joined match missed flag or trigger");
  a_join_low_quiet: assert property (joined |-> !flag_set[0] && !tick[1])
    else $error("Low flag or high timer active while joined");
  a_idle_halt: assert property (idle_mode_i && low_timer_control_reg[PT_BIT_IDLE] && !cnt_wr[0] |=>
    count_word_reg[0] == $past(count_word_reg[0]))
    else $error("Counter moved in idle with halt set");
  a_adc_joined: assert property (adc_trigger_o |-> $past(joined))
    else $error("Converter trigger while split");
  a_prescale_gap: assert property (tick[0] && low_timer_control_reg[PT_BIT_PS_LSB +: 2] != 2'h0
    && $stable(low_timer_control_reg) |-> !$past(tick[0]))
    else $error("Prescaler ticked on consecutive cycles");

  // Register side
  a_ctrl_write: assert property (reg_wr_i && reg_addr_i == PT_OFF_LOW_CTRL |=>
    low_timer_control_reg == ($past(reg_wdata_i) & PT_LOW_CTRL_MASK))
    else $error("Control write not masked as expected");
  a_period_word: assert property (reg_wr_i && reg_addr_i == PT_OFF_HIGH_PER |=>
    period_word_reg[1] == $past(reg_wdata_i))
    else $error("High period word not written");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0)
    else $error("Read data not zero outside read cycle");
  a_flag_clear: assert property (reg_wr_i && reg_addr_i == PT_OFF_IRQ_CTRL
    && reg_wdata_i[PT_BIT_FLAG_LOW] && !flag_set[0] |=> !irq_ctrl_reg[PT_BIT_FLAG_LOW])
    else $error("Low flag not cleared by write of one");
  a_flag_set_wins: assert property (flag_set[1] |=> irq_ctrl_reg[PT_BIT_FLAG_HIGH])
    else $error("High flag set lost");
  // Counting side
  a_split_high_incr: assert property (!joined && tick[1] && !match16[1] && !cnt_wr[1] |=>
    count_word_reg[1] == $past(count_word_reg[1]) + 16'h1)
    else $error("Split high timer did not increment");
  a_split_wrap: assert property (!joined && tick[0] && match16[0] && !cnt_wr[0] |=>
    count_word_reg[0] == '0 && irq_ctrl_reg[PT_BIT_FLAG_LOW])
    else $error("Split low timer did not wrap and flag");
  a_stopped_hold: assert property (!low_timer_control_reg[PT_BIT_RUN] && !cnt_wr[0] |=>
    count_word_reg[0] == $past(count_word_reg[0]))
    else $error("Low count moved while stopped");
  a_high_ignored: assert property (joined && !tick[0] && !cnt_wr[1] |=>
    count_word_reg[1] == $past(count_word_reg[1]))
    else $error("High word moved without low tick while joined");
  a_gate_closed: assert property (!low_timer_control_reg[PT_BIT_CKS] && low_timer_control_reg[PT_BIT_GATE]
    && !gate_sync_reg[0] |-> !tick[0])
    else $error("Counted with gate closed");
  a_gate_ignored: assert property (run[0] && low_timer_control_reg[PT_BIT_CKS]
    && low_timer_control_reg[PT_BIT_PS_LSB +: 2] == 2'h0 && ext_sync_reg[0] && !ext_prev_reg[0] |-> tick[0])
    else $error("Pin edge missed on external clock");
  a_idle_continue: assert property (idle_mode_i && low_timer_control_reg[PT_BIT_RUN]
    && (low_timer_control_reg & 16'h2072) == 16'h0000 |-> tick[0])
    else $error("Timer stopped in idle without halt bit");
  a_match_pulse: assert property (tb_match_o[1] |-> $past(flag_set[1]))
    else $error("High match pulse without flag set");

  c_join_wrap:   cover property (joined && tick[0] && match32);
  c_split_high:  cover property (!joined && tick[1] && match16[1]);
  c_flag_race:   cover property (flag_set[1] && reg_wr_i && reg_addr_i == PT_OFF_IRQ_CTRL);
  c_ext_counted: cover property (low_timer_control_reg[PT_BIT_CKS] && tick[0]);
  c_idle_halted: cover property (idle_mode_i && low_timer_control_reg[PT_BIT_IDLE] && low_timer_control_reg[PT_BIT_RUN]);
endmodule
`default_nettype wire

// [pt_pkg.sv]
`default_nettype none
package pt_pkg;
  // Register bus shape
  localparam int PT_DATA_W = 16;
  localparam int PT_ADDR_W = 3;

  // Register indices
  localparam logic [PT_ADDR_W-1:0] PT_OFF_LOW_CTRL  = 3'h0;
  localparam logic [PT_ADDR_W-1:0] PT_OFF_HIGH_CTRL = 3'h1;
  localparam logic [PT_ADDR_W-1:0] PT_OFF_LOW_PER   = 3'h2;
  localparam logic [PT_ADDR_W-1:0] PT_OFF_HIGH_PER  = 3'h3;
  localparam logic [PT_ADDR_W-1:0] PT_OFF_LOW_CNT   = 3'h4;
  localparam logic [PT_ADDR_W-1:0] PT_OFF_HIGH_CNT  = 3'h5;
  localparam logic [PT_ADDR_W-1:0] PT_OFF_IRQ_CTRL  = 3'h6;

  // Control register fields
  localparam int PT_BIT_RUN    = 15;
  localparam int PT_BIT_IDLE   = 13;
  localparam int PT_BIT_GATE   = 6;
  localparam int PT_BIT_PS_LSB = 4;
  localparam int PT_BIT_JOIN   = 3;
  localparam int PT_BIT_CKS    = 1;
  localparam logic [PT_DATA_W-1:0] PT_LOW_CTRL_MASK  = 16'ha07a;
  localparam logic [PT_DATA_W-1:0] PT_HIGH_CTRL_MASK = 16'ha072;

  // Interrupt control register fields
  localparam int PT_BIT_FLAG_LOW  = 0;
  localparam int PT_BIT_FLAG_HIGH = 1;
  localparam int PT_BIT_EN_LOW    = 2;
  localparam int PT_BIT_EN_HIGH   = 3;
  localparam int PT_PRI_LOW_LSB   = 4;
  localparam int PT_PRI_HIGH_LSB  = 8;
  localparam int PT_PRI_W         = 3;
  localparam logic [PT_DATA_W-1:0] PT_IRQ_RW_MASK = 16'h077c;

  // Values after reset
  localparam logic [PT_DATA_W-1:0] PT_CTRL_RST = 16'h0000;
  localparam logic [PT_DATA_W-1:0] PT_PER_RST  = 16'hffff;
  localparam logic [PT_DATA_W-1:0] PT_CNT_RST  = 16'h0000;
  localparam logic [PT_DATA_W-1:0] PT_IRQ_RST  = 16'h0000;

  // Prescaler terminal counts (ratio minus one)
  localparam int PT_PS_TERM_1   = 0;
  localparam int PT_PS_TERM_8   = 7;
  localparam int PT_PS_TERM_64  = 63;
  localparam int PT_PS_TERM_256 = 255;
endpackage
`default_nettype wire

// [pt_pin_model.sv]
`default_nettype none
module pt_pin_model (
  // Clock
  input  wire logic       core_clk_i,
  // Pins toward the timer pair
  output logic      [1:0] external_count_pin_o,
  output logic      [1:0] gate_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    external_count_pin_o = 2'h0;
    gate_pin_o           = 2'h0;
  end

  // Pulses are held three clocks so the two-flop synchroniser cannot miss one
  task automatic send_edges(input int n);
    for (int i = 0; i < n; i++) begin
      external_count_pin_o[0] <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      external_count_pin_o[0] <= 1'b0;
      repeat (3) @(posedge core_clk_i);
    end
  endtask

  task automatic set_gate(input logic lvl);
    gate_pin_o[0] <= lvl;
  endtask
endmodule
`default_nettype wire

// [test_paired_timer_16_32.sv]
`default_nettype none
module test_paired_timer_16_32;
  timeunit 1ns;
  timeprecision 1ps;
  import pt_pkg::*;

  logic                 core_clk_i;
  logic                 reset_i;
  logic [PT_ADDR_W-1:0] reg_addr_i;
  logic [PT_DATA_W-1:0] reg_wdata_i;
  logic [PT_DATA_W-1:0] reg_rdata_o;
  logic                 reg_wr_i;
  logic                 reg_rd_i;
  logic                 idle_mode_i;
  logic [1:0]           ext_pin;
  logic [1:0]           gate_pin;
  logic [1:0]           irq_req_o;
  logic [1:0]           tb_match_o;
  logic [2:0]           pri_low;
  logic [2:0]           pri_high;
  logic [15:0]          tb_lo;
  logic [15:0]          tb_hi;
  logic                 adc_trig;
  logic                 joined;
  logic [15:0]          v;
  int                   err_total;
  int                   checks_done;
  int                   match_cnt;
  int                   adc_cnt;
  int                   hi_cnt;
  int                   ratio [4] = '{1, 8, 64, 256};

  pt_paired_timer dut_u (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .external_count_pin_i(ext_pin),
    .gate_pin_i(gate_pin), .idle_mode_i(idle_mode_i), .irq_req_o(irq_req_o),
    .pair_irq_priority_low_o(pri_low), .pair_irq_priority_o(pri_high), .tb_count_low_o(tb_lo),
    .tb_count_high_o(tb_hi), .tb_match_o(tb_match_o), .adc_trigger_o(adc_trig), .pair_joined_o(joined)
  );

  pt_pin_model pin_u (
    .core_clk_i(core_clk_i), .external_count_pin_o(ext_pin), .gate_pin_o(gate_pin)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    if (tb_match_o[0] === 1'b1) match_cnt++;
    if (adc_trig === 1'b1) adc_cnt++;
    if (tb_match_o[1] === 1'b1) hi_cnt++;
  end

  // A gap cycle after each strobe keeps a strobe from being driven twice in one step
  task automatic wr(input logic [PT_ADDR_W-1:0] a, input logic [PT_DATA_W-1:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rd(input logic [PT_ADDR_W-1:0] a, output logic [PT_DATA_W-1:0] d);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    d = reg_rdata_o;
    @(posedge core_clk_i);
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input string what, input logic [PT_ADDR_W-1:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  // Run is sampled on the first write, stop on the second: n ticks in between
  task automatic run_ticks(input logic [15:0] ctrl, input int n);
    wr(PT_OFF_LOW_CTRL, ctrl | (16'h0001 << PT_BIT_RUN));
    repeat (n - 2) @(posedge core_clk_i);
    wr(PT_OFF_LOW_CTRL, ctrl);
  endtask

  task automatic endt(input string n);
    $display("test %s done", n);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    reset_i = 1'b1; reg_addr_i = '0; reg_wdata_i = '0; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
    idle_mode_i = 1'b0; err_total = 0; checks_done = 0; match_cnt = 0; adc_cnt = 0;
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    for (int a = 0; a < 8; a++)
      rdchk("reset value", a[PT_ADDR_W-1:0], (a == 2 || a == 3) ? PT_PER_RST : 16'h0000);
    wr(PT_OFF_LOW_CTRL, 16'h7fff);
    rdchk("low control bits", PT_OFF_LOW_CTRL, PT_LOW_CTRL_MASK & 16'h7fff);
    wr(PT_OFF_HIGH_CTRL, 16'hffff);
    rdchk("high control bits", PT_OFF_HIGH_CTRL, PT_HIGH_CTRL_MASK);
    wr(PT_OFF_IRQ_CTRL, 16'hffff);
    rdchk("irq control bits", PT_OFF_IRQ_CTRL, PT_IRQ_RW_MASK);
    wr(3'h7, 16'hffff);
    rdchk("unmapped", 3'h7, 16'h0000);
    wr(PT_OFF_LOW_CTRL, 16'h0000);
    wr(PT_OFF_HIGH_CTRL, 16'h0000);
    wr(PT_OFF_IRQ_CTRL, 16'h0000);
    endt("registers");
    for (int p = 0; p < 4; p++) begin
      wr(PT_OFF_LOW_CNT, 16'h0000);
      run_ticks(16'(p << PT_BIT_PS_LSB), 3 * ratio[p] + ratio[p] / 2);
      rdchk("prescaled count", PT_OFF_LOW_CNT, 16'h0003);
    end
    endt("prescale");
    wr(PT_OFF_LOW_CNT, 16'h0000);
    wr(PT_OFF_LOW_PER, 16'h0002);
    wr(PT_OFF_IRQ_CTRL, 16'h0034);
    match_cnt = 0;
    run_ticks(16'h0000, 7);
    rdchk("split count", PT_OFF_LOW_CNT, 16'h0001);
    chk("match pulses", 16'h0002, 16'(match_cnt));
    rdchk("low flag", PT_OFF_IRQ_CTRL, 16'h0035);
    chk("low request", 16'h0001, {15'h0, irq_req_o[0]});
    chk("low priority", 16'h0003, {13'h0, pri_low});
    wr(PT_OFF_IRQ_CTRL, 16'h0035);
    rdchk("flag cleared", PT_OFF_IRQ_CTRL, 16'h0034);
    chk("request cleared", 16'h0000, {15'h0, irq_req_o[0]});
    endt("split");
    wr(PT_OFF_HIGH_CTRL, 16'h8032);
    wr(PT_OFF_LOW_CTRL, 16'h0008);
    wr(PT_OFF_LOW_PER, 16'h0003);
    wr(PT_OFF_HIGH_PER, 16'h0001);
    wr(PT_OFF_IRQ_CTRL, 16'h0508);
    wr(PT_OFF_LOW_CNT, 16'hffff);
    match_cnt = 0;
    adc_cnt = 0;
    hi_cnt = 0;
    run_ticks(16'h0008, 4);
    rdchk("joined low word", PT_OFF_LOW_CNT, 16'h0003);
    rdchk("joined high word", PT_OFF_HIGH_CNT, 16'h0001);
    chk("time base high", 16'h0001, tb_hi);
    chk("joined level", 16'h0001, {15'h0, joined});
    run_ticks(16'h0008, 2);
    rdchk("wrapped low word", PT_OFF_LOW_CNT, 16'h0001);
    rdchk("wrapped high word", PT_OFF_HIGH_CNT, 16'h0000);
    rd(PT_OFF_IRQ_CTRL, v);
    chk("joined flag", 16'h050a, v & 16'hfffe);
    chk("joined request", 16'h0001, {15'h0, irq_req_o[1]});
    chk("joined priority", 16'h0005, {13'h0, pri_high});
    chk("converter pulses", 16'h0001, 16'(adc_cnt));
    chk("joined match pulses", 16'h0001, 16'(match_cnt));
    chk("joined high pulses", 16'h0001, 16'(hi_cnt));
    wr(PT_OFF_IRQ_CTRL, 16'h0003);
    wr(PT_OFF_LOW_CTRL, 16'h0000);
    wr(PT_OFF_HIGH_CTRL, 16'h0000);
    wr(PT_OFF_LOW_PER, 16'hffff);
    wr(PT_OFF_LOW_CNT, 16'h0000);
    endt("joined");
    wr(PT_OFF_HIGH_PER, 16'h0004);
    hi_cnt = 0;
    wr(PT_OFF_HIGH_CTRL, 16'h8000);
    repeat (5) @(posedge core_clk_i);
    wr(PT_OFF_HIGH_CTRL, 16'h0000);
    rdchk("split high count", PT_OFF_HIGH_CNT, 16'h0002);
    rdchk("high flag", PT_OFF_IRQ_CTRL, 16'h0002);
    chk("high pulses", 16'h0001, 16'(hi_cnt));
    rdchk("low count untouched", PT_OFF_LOW_CNT, 16'h0000);
    wr(PT_OFF_IRQ_CTRL, 16'h0002);
    endt("split high");
    pin_u.set_gate(1'b0);
    run_ticks(16'h0040, 10);
    rdchk("gate closed", PT_OFF_LOW_CNT, 16'h0000);
    pin_u.set_gate(1'b1);
    repeat (4) @(posedge core_clk_i);
    run_ticks(16'h0040, 10);
    rdchk("gate open", PT_OFF_LOW_CNT, 16'h000a);
    pin_u.set_gate(1'b0);
    wr(PT_OFF_LOW_CNT, 16'h0000);
    wr(PT_OFF_LOW_CTRL, 16'h8042);
    pin_u.send_edges(5);
    repeat (4) @(posedge core_clk_i);
    wr(PT_OFF_LOW_CTRL, 16'h0042);
    rdchk("pin edges", PT_OFF_LOW_CNT, 16'h0005);
    endt("clock and gate");
    wr(PT_OFF_LOW_CNT, 16'h0000);
    idle_mode_i <= 1'b1;
    run_ticks(16'h2000, 10);
    rdchk("halted in idle", PT_OFF_LOW_CNT, 16'h0000);
    run_ticks(16'h0000, 10);
    rdchk("counting in idle", PT_OFF_LOW_CNT, 16'h000a);
    chk("time base low", 16'h000a, tb_lo);
    idle_mode_i <= 1'b0;
    endt("idle");
    tally_and_finish();
  end
endmodule
`default_nettype wire
